// *** hdl/cafc_top.sv ***
// acceptance filter control for filters 0 to 7 with match and route logic
`timescale 1ns/1ps
// Notes on behaviour
// - each filter byte: bit7 enable, bits 6:5 mask choice, bits 4:0 fifo target
// - first register holds filters 0-3, second 4-7, low filter in low byte
// - only an enabled filter takes part in matching
// - mask choice code n picks acceptance mask n
// - matching message goes to the fifo named by fifo target
// - mask choice and fifo target change only while that filter is disabled
// - clear alias at base plus 4 clears written one bits
// - set alias at base plus 8 sets written one bits
// - invert alias at base plus 12 toggles written one bits
// - all filter bits read and write, reset to zero
// - mask bit one compares that identifier bit, zero is don't care
// - id type bit one requires matching frame type, zero accepts either
module cafc_top
   import cafc_pkg::*;
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic [7:0]           addr_i,
   input  wire logic [31:0]          wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [31:0]          rdata_o,
   input  wire logic                 msg_valid_i,
   input  wire logic [28:0]          msg_id_i,
   input  wire logic                 msg_ext_i,
   input  wire logic [7:0][28:0]     filt_id_i,
   input  wire logic [7:0]           filt_ext_i,
   output logic                      accept_o,
   output logic [4:0]                fifo_o,
   output logic [2:0]                hit_filter_o,
   output logic [7:0]                filt_enable_o
);
   import cafc_pkg::*;

   logic [1:0][31:0] ctrl_q, ctrl_d;
   logic [3:0][31:0] mask_q, mask_d;
   logic [31:0]      rdata_q, rdata_d;
   logic             accept_q, accept_d;
   logic [4:0]       fifo_q, fifo_d;
   logic [2:0]       hit_q, hit_d;

   // applies an alias operation to the old value
   function automatic logic [31:0] alias_op(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [1:0]  op);
      logic [31:0] r;
      r = old;
      case (op)
         2'h0:    r = wd;
         2'h1:    r = old & ~wd;
         2'h2:    r = old | wd;
         2'h3:    r = old ^ wd;
         default: r = old;
      endcase
      return r;
   endfunction

   // filter byte of filter f out of the control pair
   function automatic logic [7:0] fbyte(input logic [1:0][31:0] c, input int f);
      return c[f / 4][(f % 4) * 8 +: 8];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // register writes
   always_comb begin
      logic [31:0] nv;
      logic [31:0] cur;
      logic [1:0]  op;
      nv  = READ_ZERO;
      cur = READ_ZERO;
      op  = addr_i[3:2];
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      if (wr_i && addr_i[7:5] == 3'h0) begin
         cur = ctrl_q[addr_i[4]];
         nv  = alias_op(cur, wdata_i, op);
         for (int b = 0; b < 4; b++) begin
            // enable always writable; others only while enable was clear
            ctrl_d[addr_i[4]][b * 8 + POS_ENABLE] = nv[b * 8 + POS_ENABLE];
            if (!cur[b * 8 + POS_ENABLE]) begin
               ctrl_d[addr_i[4]][b * 8 +: 7] = nv[b * 8 +: 7];
            end
         end
      end
      // masks sit on 8-byte steps; odd words are holes, not second copies
      if (wr_i && addr_i[7:6] == 2'h0 && addr_i[5] && addr_i[2:0] == 3'h0) begin
         mask_d[addr_i[4:3]] = wdata_i & MASK_IMPL;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read path, data one cycle after the strobe
   always_comb begin
      rdata_d = READ_ZERO;
      if (rd_i) begin
         if (addr_i == OFS_CTRL_0_3) begin
            rdata_d = ctrl_q[0];
         end else if (addr_i == OFS_CTRL_4_7) begin
            rdata_d = ctrl_q[1];
         end else if (addr_i[7:5] == 3'h1 && addr_i[2:0] == 3'h0) begin
            rdata_d = mask_q[addr_i[4:3]];
         end else if (addr_i == OFS_MATCH) begin
            rdata_d = {23'h0, accept_q, fifo_q, hit_q};
         end
         // aliases and unmapped offsets read zero
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // match engine; lowest numbered hitting filter wins
   always_comb begin
      logic [7:0]  fb;
      logic [31:0] m;
      logic [28:0] cm;
      logic        hit;
      fb = 8'h00;
      m  = READ_ZERO;
      cm = 29'h0;
      hit = 1'b0;
      accept_d = 1'b0;
      fifo_d   = fifo_q;
      hit_d    = hit_q;
      if (msg_valid_i) begin
         for (int f = NUM_FILT - 1; f >= 0; f--) begin
            fb = fbyte(ctrl_q, f);
            m  = mask_q[fb[POS_MASK_LO +: 2]];
            cm = {m[POS_M_SID +: 11], m[17:0]};
            hit = (((msg_id_i ^ filt_id_i[f]) & cm) == 29'h0);
            if (m[POS_M_IDE] && (msg_ext_i != filt_ext_i[f])) begin
               hit = 1'b0;
            end
            if (fb[POS_ENABLE] && hit) begin
               accept_d = 1'b1;
               fifo_d   = fb[POS_FIFO_LO +: 5];
               hit_d    = f[2:0];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q   <= {CTRL_RESET, CTRL_RESET};
         mask_q   <= {MASK_RESET, MASK_RESET, MASK_RESET, MASK_RESET};
         rdata_q  <= READ_ZERO;
         accept_q <= 1'b0;
         fifo_q   <= 5'h00;
         hit_q    <= 3'h0;
         filt_enable_o <= 8'h00;
      end else begin
         ctrl_q   <= ctrl_d;
         mask_q   <= mask_d;
         rdata_q  <= rdata_d;
         accept_q <= accept_d;
         fifo_q   <= fifo_d;
         hit_q    <= hit_d;
         for (int f = 0; f < NUM_FILT; f++) begin
            filt_enable_o[f] <= ctrl_d[f / 4][(f % 4) * 8 + POS_ENABLE];
         end
      end
   end

   assign rdata_o      = rdata_q;
   assign accept_o     = accept_q;
   assign fifo_o       = fifo_q;
   assign hit_filter_o = hit_q;
endmodule // cafc_top

// *** common/cafc_pkg.sv ***
// constants and types for the acceptance filter control block
package cafc_pkg;
   localparam int unsigned ADDR_W        = 8;
   localparam int unsigned DATA_W        = 32;
   localparam int unsigned NUM_FILT      = 8;
   localparam int unsigned NUM_MASK      = 4;
   localparam int unsigned ID_W          = 29;
   // register offsets, byte addresses
   localparam logic [7:0]  OFS_CTRL_0_3  = 8'h00;
   localparam logic [7:0]  OFS_CTRL_4_7  = 8'h10;
   localparam logic [7:0]  OFS_CLR_ALIAS = 8'h04;
   localparam logic [7:0]  OFS_SET_ALIAS = 8'h08;
   localparam logic [7:0]  OFS_INV_ALIAS = 8'h0C;
   localparam logic [7:0]  OFS_MASK_BASE = 8'h20;
   localparam logic [7:0]  OFS_MATCH     = 8'h40;
   // field positions within one filter byte
   localparam int unsigned POS_ENABLE    = 7;
   localparam int unsigned POS_MASK_LO   = 5;
   localparam int unsigned POS_FIFO_LO   = 0;
   // mask register layout: sid 31:21, id type 19, eid 17:0
   localparam int unsigned POS_M_SID     = 21;
   localparam int unsigned POS_M_IDE     = 19;
   localparam logic [31:0] MASK_IMPL     = 32'hFFEB_FFFF;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO     = 32'h0000_0000;
   typedef enum logic [1:0] {CAFC_WR_PLAIN, CAFC_WR_CLR, CAFC_WR_SET, CAFC_WR_INV} cafc_wr_t;
endpackage

// *** verification/cafc_monitor.sv ***
// port checks for the filter control block
`timescale 1ns/1ps
module cafc_mon (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   input wire logic        msg_valid_i,
   input wire logic        accept_o,
   input wire logic [4:0]  fifo_o,
   input wire logic [7:0]  filt_enable_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("stray read data");
   a_accept_cause: assert property (accept_o |-> $past(msg_valid_i) && $past(filt_enable_o) != 0)
      else $error("accept without enabled filter");
   a_fifo_holds: assert property (!$past(msg_valid_i) |-> $stable(fifo_o))
      else $error("fifo moved");
   a_set_en: assert property (wr_i && addr_i == 8'h08 && wdata_i[7] |=> filt_enable_o[0])
      else $error("set alias");
   a_clr_en: assert property (wr_i && addr_i == 8'h14 && wdata_i[31] |=> !filt_enable_o[7])
      else $error("clear alias");
   a_inv_en: assert property (wr_i && addr_i == 8'h0C |=> filt_enable_o[3:0] ==
      ($past(filt_enable_o[3:0]) ^ $past({wdata_i[31], wdata_i[23], wdata_i[15], wdata_i[7]})))
      else $error("invert alias");
   a_plain_en: assert property (wr_i && addr_i == 8'h10 |=> filt_enable_o[7:4] ==
      $past({wdata_i[31], wdata_i[23], wdata_i[15], wdata_i[7]})) else $error("plain write");
   a_en_steady: assert property (!wr_i |=> $stable(filt_enable_o))
      else $error("enable moved");
endmodule // cafc_mon
bind cafc_top cafc_mon u_mon (.*);

// *** verification/cafc_top_test.sv ***
// random bench with reference model for the filter control block
`timescale 1ns/1ps
module cafc_top_test;
   import cafc_pkg::*;
   logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, msg_valid_i = 0, msg_ext_i = 0, accept_o;
   logic [7:0]  addr_i = 8'h00, filt_ext_i = 8'h00, filt_enable_o, a, b, hf = 8'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o, d, o, v1 = 32'h0, v2 = 32'h0;
   logic [31:0] m [2] = '{32'h0, 32'h0};
   logic [28:0] msg_id_i = 29'h0, mi;
   logic [7:0][28:0] filt_id_i = '0, fi;
   logic [4:0]  fifo_o;
   logic [2:0]  hit_filter_o;
   int          n_mismatch = 0, num_checks = 0, r, k1 = 0, k2 = 0;
   cafc_top uut (.*);
   initial forever #5 clk_i = ~clk_i;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #40000;
      n_mismatch++;
      results();
   end
   initial begin
      r = $urandom(71286);
      repeat (4) @(posedge clk_i);
      rst_i <= 0;
      // mask 1 compares the whole id, masks 0 and 2 stay don't care
      addr_i <= 8'h28; wdata_i <= 32'hFFE3FFFF; wr_i <= 1;
      // mask 3 compares only the frame type
      @(posedge clk_i);
      addr_i <= 8'h38; wdata_i <= 32'h00080000;
      for (int i = 0; i < 3000; i++) begin
         // outputs are looked at mid-cycle, away from the launching edge
         @(negedge clk_i);
         chk(rdata_o, k2 == 1 ? v2 : 32'h0);
         if (k2 == 2) chk({accept_o, fifo_o, hit_filter_o}, v2);
         @(posedge clk_i);
         k2 = k1; v2 = v1; k1 = $urandom % 3; v1 = 32'h0; d = $urandom;
         a = (i % 50 == 7) ? 8'h60 : (i % 50 == 9) ? 8'h40 : 8'(($urandom % 8) << 2);
         wr_i <= k1 == 0; rd_i <= k1 == 1; msg_valid_i <= k1 == 2;
         addr_i <= a; wdata_i <= d;
         if (k1 == 0 && a < 8'h20) begin
            o = m[a[4]];
            case (a[3:2])
               2'd0: v1 = d;
               2'd1: v1 = o & ~d;
               2'd2: v1 = o | d;
               default: v1 = o ^ d;
            endcase
            for (int f = 0; f < 4; f++) if (o[8*f+7]) v1[8*f +: 7] = o[8*f +: 7];
            m[a[4]] = v1;
         end
         if (k1 == 1 && a[3:2] == 2'd0 && a < 8'h20) v1 = m[a[4]];
         if (k1 == 1 && a == 8'h40) v1 = {23'h0, k2 == 2 && v2[8], hf};
         if (k1 == 2) begin
            mi = 29'($urandom % 4);
            for (int f = 0; f < 8; f++) fi[f] = 29'($urandom % 4);
            msg_id_i <= mi; filt_id_i <= fi; msg_ext_i <= d[0]; filt_ext_i <= d[15:8];
            v1 = {24'h0, hf};
            // descending so the lowest numbered hit wins
            for (int f = 7; f >= 0; f--) begin
               b = m[f / 4][8 * (f % 4) +: 8];
               if (b[7] && (b[6:5] == 2'd1 ? fi[f] == mi : b[6:5] != 2'd3 || d[0] == d[8 + f]))
                  v1 = {23'h0, 1'b1, b[4:0], 3'(f)};
            end
            hf = v1[7:0];
         end
      end
      $display("random register and match test done");
      results();
   end
endmodule // cafc_top_test
